// ===== card_target_model.sv
`timescale 1ns/100ps
// =====================================================
// card target stand-in
// ends each forwarded access that starts while it is idle, promptly or slowly
module card_target_model (
    input wire logic clk_i, // pci clock
    input wire logic frame_n_i, // pci frame, low active
    input wire logic slow_i, // stretch the answer
    output logic done_o // access finished pulse
);
    logic [2:0] cnt_q = 3'h0; // cycles left to finish
    logic done_q = 1'b0; // registered finish pulse
    assign done_o = done_q;
    // always finishes, so no access is blocked for good
    always_ff @(posedge clk_i) begin
        done_q <= (cnt_q == 3'h1);
        if (!frame_n_i && cnt_q == 3'h0) begin
            cnt_q <= slow_i ? 3'h6 : 3'h2;
        end else if (cnt_q != 3'h0) begin
            cnt_q <= cnt_q - 3'h1;
        end
    end
endmodule

// ===== lock_bridge_params.svh
`ifndef LOCK_BRIDGE_PARAMS_SVH
`define LOCK_BRIDGE_PARAMS_SVH
// =====================================================================
// lock granularity and address widths
`define LOCK_GRAIN_BITS 4
`define LOCK_ADDR_W 32
// routing code that places the bus lock input on multipurpose pin four
`define LOCK_ROUTE_CODE 4'h5
`define LOCK_ROUTE_W 4
`endif

// ===== lock_bridge_pkg.sv
package lock_bridge_pkg;
    // lock tracker states
    typedef enum logic [1:0] {
        LK_FREE,
        LK_ARMED,
        LK_HELD,
        LK_RELEASE
    } lock_state_t;
endpackage

// ===== lock_region_cmp.sv
`timescale 1ns/100ps
`include "lock_bridge_params.svh"
// =====================================================================
// compare a probe address with the recorded 16-byte aligned block
module lock_region_cmp #(
    parameter int AW = `LOCK_ADDR_W,
    parameter int GB = `LOCK_GRAIN_BITS
) (
    lock_region_if.cmp rif // region record and probe
);
    // low address bits ignored: the block is naturally aligned
    assign rif.hit = rif.valid &&
        (rif.probe[AW-1:GB] == rif.base[AW-1:GB]);
endmodule

// ===== lock_region_if.sv
`timescale 1ns/100ps
`include "lock_bridge_params.svh"
// =====================================================================
// region record shared between tracker and compare
interface lock_region_if #(parameter int AW = `LOCK_ADDR_W);
    logic valid; // a region is recorded
    logic [AW-1:0] base; // recorded address
    logic [AW-1:0] probe; // address under test
    logic hit; // probe falls in recorded block
    modport owner (output valid, output base, output probe, input hit);
    modport cmp (input valid, input base, input probe, output hit);
endinterface

// ===== pci_lock_bridge_control.sv
`timescale 1ns/100ps
`include "lock_bridge_params.svh"
module pci_lock_bridge_control #(
    parameter int AW = `LOCK_ADDR_W
) (
    input wire logic CLK_I, // pci clock, 25 mhz
    input wire logic SRST_I, // pci bus reset, sync high
    input wire logic CE_I, // clock enable, freezes state
    input wire logic [`LOCK_ROUTE_W-1:0] ROUTE_SEL_I, // pin four routing
    input wire logic MULTIPURPOSE_PIN_FOUR_N_I, // lock pin, low active
    input wire logic FRAME_N_I, // pci frame, low active
    input wire logic [AW-1:0] ADDR_I, // address phase value
    input wire logic TARGETED_I, // access decoded to bridge
    input wire logic CARD_LOCK_REQ_N_I, // card side lock input
    input wire logic XFER_DONE_I, // forwarded access finished
    output logic CARD_SIDE_LOCK_N_O, // card side lock drive, low
    output logic CARD_SIDE_LOCK_OE_O, // card side lock enable
    output logic POST_EN_O, // write posting allowed
    output logic ACCEPT_O, // take this access
    output logic RETRY_O, // retry: collides with lock
    output logic LOCKED_O // lock held through bridge
);
    // =================================================================
    // pin synchroniser, three stages, change when last two agree
    logic [2:0] lk_sync_q;
    logic lk_pin_q; // filtered lock level, 1 = asserted
    logic route_ok; // lock pin is routed
    lock_bridge_pkg::lock_state_t st_q;
    logic frame_q; // previous frame level (asserted)
    logic start; // address phase begins
    lock_region_if #(.AW(AW)) rif();

    assign route_ok = (ROUTE_SEL_I == `LOCK_ROUTE_CODE);
    assign start = !FRAME_N_I && !frame_q;

    // sync chain, raw stage read only by the next stage
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            lk_sync_q <= 3'h0;
        end else if (CE_I) begin
            lk_sync_q <= {lk_sync_q[1:0], !MULTIPURPOSE_PIN_FOUR_N_I};
        end
    end

    // filtered level; unrouted pin is treated as never asserted
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            lk_pin_q <= 1'b0;
        end else if (CE_I) begin
            if (!route_ok) begin
                lk_pin_q <= 1'b0;
            end else if (lk_sync_q[1] == lk_sync_q[2]) begin
                lk_pin_q <= lk_sync_q[2];
            end
        end
    end

    // frame edge tracking
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            frame_q <= 1'b0;
        end else if (CE_I) begin
            frame_q <= !FRAME_N_I;
        end
    end

    // =================================================================
    // lock tracker; ownership from lock handshake only, no grant seen
    // lock deasserted at address phase plus targeted, with pin four routed, arms ownership
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            st_q <= lock_bridge_pkg::LK_FREE;
        end else if (CE_I) begin
            case (st_q)
                lock_bridge_pkg::LK_FREE: begin
                    // lock high at start, then low: handshake begins
                    if (start && TARGETED_I && !lk_pin_q && route_ok) begin
                        st_q <= lock_bridge_pkg::LK_ARMED;
                    end
                end
                lock_bridge_pkg::LK_ARMED: begin
                    if (lk_pin_q) begin
                        st_q <= lock_bridge_pkg::LK_HELD;
                    end else if (FRAME_N_I && XFER_DONE_I) begin
                        st_q <= lock_bridge_pkg::LK_FREE;
                    end
                end
                lock_bridge_pkg::LK_HELD: begin
                    // owner lets lock go at end of final transaction
                    if (!lk_pin_q && FRAME_N_I) begin
                        st_q <= lock_bridge_pkg::LK_RELEASE;
                    end
                end
                lock_bridge_pkg::LK_RELEASE: begin
                    st_q <= lock_bridge_pkg::LK_FREE;
                end
                default: begin
                    st_q <= lock_bridge_pkg::LK_FREE;
                end
            endcase
        end
    end

    // region record, captured at the locked address phase
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            rif.valid <= 1'b0;
            rif.base <= '0;
        end else if (CE_I) begin
            if (st_q == lock_bridge_pkg::LK_FREE && start &&
                TARGETED_I && route_ok) begin
                rif.base <= ADDR_I;
            end
            if (st_q == lock_bridge_pkg::LK_ARMED && lk_pin_q) begin
                rif.valid <= 1'b1;
            end else if (st_q == lock_bridge_pkg::LK_RELEASE) begin
                rif.valid <= 1'b0;
            end
        end
    end

    assign rif.probe = ADDR_I;

    lock_region_cmp #(.AW(AW)) u_cmp (
        .rif(rif)
    );

    // =================================================================
    // accept or retry; only the locked block is refused to others
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            ACCEPT_O <= 1'b0;
            RETRY_O <= 1'b0;
        end else if (CE_I) begin
            ACCEPT_O <= 1'b0;
            RETRY_O <= 1'b0;
            if (start && TARGETED_I) begin
                // non-exclusive access to locked block while held
                if (rif.hit && lk_pin_q &&
                    st_q == lock_bridge_pkg::LK_HELD) begin
                    RETRY_O <= 1'b1;
                end else begin
                    ACCEPT_O <= 1'b1;
                end
            end
        end
    end

    // posting off while any locked operation is under way
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            POST_EN_O <= 1'b1;
        end else if (CE_I) begin
            POST_EN_O <= (st_q == lock_bridge_pkg::LK_FREE) &&
                !(start && TARGETED_I && route_ok);
        end
    end

    // card side lock driven downstream only; card lock input ignored
    // so that no lock ever flows toward the processor
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            CARD_SIDE_LOCK_N_O <= 1'b1;
            CARD_SIDE_LOCK_OE_O <= 1'b0;
            LOCKED_O <= 1'b0;
        end else if (CE_I) begin
            CARD_SIDE_LOCK_OE_O <= (st_q != lock_bridge_pkg::LK_FREE);
            CARD_SIDE_LOCK_N_O <= !(st_q == lock_bridge_pkg::LK_HELD ||
                (st_q == lock_bridge_pkg::LK_ARMED && lk_pin_q));
            LOCKED_O <= (st_q == lock_bridge_pkg::LK_HELD);
        end
    end

    // =================================================================
    // checks
    posting_off_a: assert property (@(posedge CLK_I)
        disable iff (SRST_I)
        CE_I && $past(CE_I) && $past(st_q) == lock_bridge_pkg::LK_HELD
        |-> !POST_EN_O) else $error("posting on during lock");
    // frozen state may keep the old level, so the first cycle needs CE_I
    unrouted_idle_a: assert property (@(posedge CLK_I)
        disable iff (SRST_I)
        CE_I && !route_ok ##1 !route_ok ##1 !route_ok |->
        st_q != lock_bridge_pkg::LK_HELD || !lk_pin_q)
        else $error("lock honoured while unrouted");
    outside_ok_a: assert property (@(posedge CLK_I)
        disable iff (SRST_I)
        CE_I && start && TARGETED_I && !rif.hit |=> ACCEPT_O && !RETRY_O)
        else $error("outside access refused");
    // hit exactly when the recorded block matches, never elsewhere
    region_grain_a: assert property (@(posedge CLK_I)
        disable iff (SRST_I)
        rif.hit == (rif.valid &&
        ADDR_I[AW-1:`LOCK_GRAIN_BITS] == rif.base[AW-1:`LOCK_GRAIN_BITS]))
        else $error("aligned block mismatch");
    // a foreign access into the held block is always retried
    inside_retry_a: assert property (@(posedge CLK_I)
        disable iff (SRST_I)
        CE_I && start && TARGETED_I && rif.valid && lk_pin_q &&
        st_q == lock_bridge_pkg::LK_HELD &&
        ADDR_I[AW-1:`LOCK_GRAIN_BITS] == rif.base[AW-1:`LOCK_GRAIN_BITS]
        |=> RETRY_O && !ACCEPT_O) else $error("locked block accepted");
    region_release_a: assert property (@(posedge CLK_I)
        disable iff (SRST_I)
        CE_I && st_q == lock_bridge_pkg::LK_RELEASE |=> !rif.valid)
        else $error("region kept after release");
    card_lock_a: assert property (@(posedge CLK_I)
        disable iff (SRST_I)
        CE_I && $past(CE_I) && $past(st_q) == lock_bridge_pkg::LK_HELD
        |-> !CARD_SIDE_LOCK_N_O && CARD_SIDE_LOCK_OE_O)
        else $error("card lock not driven");
    no_upstream_a: assert property (@(posedge CLK_I)
        disable iff (SRST_I)
        CE_I && st_q == lock_bridge_pkg::LK_FREE && !start |=>
        st_q == lock_bridge_pkg::LK_FREE)
        else $error("lock taken without pci handshake");
    both_retry_a: assert property (@(posedge CLK_I)
        disable iff (SRST_I)
        !(ACCEPT_O && RETRY_O)) else $error("accept and retry");
endmodule

// ===== test_pci_lock_bridge_control.sv
`timescale 1ns/100ps
// =====================================================
// bench for the lock tracker
module test_pci_lock_bridge_control;
    logic clk = 1'b0; // pci clock
    logic srst = 1'b1; // sync reset
    logic ce = 1'b1; // clock enable
    logic [3:0] route = 4'h5; // pin four routing
    logic pin_n = 1'b1; // bus lock pin
    logic frame_n = 1'b1; // frame
    logic [31:0] addr = 32'h0; // address
    logic [31:0] base; // locked address
    logic [31:0] a; // scratch address
    logic tgt = 1'b0; // decoded to bridge
    logic card_req_n = 1'b1; // card side lock request
    logic slow = 1'b1; // partner pace
    logic done, lk_n, lk_oe, post_en, accept, retry, locked;
    int err_count = 0;
    int checks = 0;
    pci_lock_bridge_control dut (.CLK_I(clk), .SRST_I(srst), .CE_I(ce),
        .ROUTE_SEL_I(route), .MULTIPURPOSE_PIN_FOUR_N_I(pin_n),
        .FRAME_N_I(frame_n), .ADDR_I(addr), .TARGETED_I(tgt),
        .CARD_LOCK_REQ_N_I(card_req_n), .XFER_DONE_I(done),
        .CARD_SIDE_LOCK_N_O(lk_n), .CARD_SIDE_LOCK_OE_O(lk_oe),
        .POST_EN_O(post_en), .ACCEPT_O(accept), .RETRY_O(retry),
        .LOCKED_O(locked));
    card_target_model partner (.clk_i(clk), .frame_n_i(frame_n),
        .slow_i(slow), .done_o(done));
    // free running clock, 40 ns
    initial begin
        forever #20 clk = ~clk;
    end
    // =====================================================
    // helpers
    task automatic chk(input logic got, input logic exp, input string m);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask
    task automatic close_out;
        $display("mismatches %0d checks %0d", err_count, checks);
        if (err_count == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // same 16-byte block as the held one
    function automatic logic hits(input logic [31:0] x, input logic [31:0] b);
        return x[31:4] == b[31:4];
    endfunction
    // one targeted access; lk sets the lock pin after the address phase
    task automatic access(input logic [31:0] x, input logic lk,
        input logic exp_r, input string m);
        int na;
        int nr;
        na = 0;
        nr = 0;
        frame_n = 1'b0;
        addr = x;
        tgt = 1'b1;
        @(negedge clk);
        frame_n = 1'b1;
        tgt = 1'b0;
        pin_n = ~lk;
        // exactly one answer pulse is expected
        repeat (3) begin
            na += int'(accept === 1'b1);
            nr += int'(retry === 1'b1);
            @(negedge clk);
        end
        chk(na == int'(!exp_r) && nr == int'(exp_r), 1'b1, m);
    endtask
    // =====================================================
    // main sequence
    initial begin
        void'($urandom(50701));
        repeat (2) @(negedge clk);
        srst = 1'b0;
        chk(post_en, 1'b1, "posting after reset");
        chk(lk_oe, 1'b0, "card lock idle after reset");
        // a lock from the card side is never carried upward
        card_req_n = 1'b0;
        repeat (6) @(negedge clk);
        chk(locked, 1'b0, "upstream lock seen");
        card_req_n = 1'b1;
        // lock pin ignored while pin four carries something else
        route = 4'($urandom_range(4, 0));
        access($urandom, 1'b1, 1'b0, "unrouted access");
        repeat (6) @(negedge clk);
        chk(locked, 1'b0, "unrouted lock taken");
        chk(lk_n, 1'b1, "unrouted card lock");
        pin_n = 1'b1;
        repeat (8) @(negedge clk);
        route = 4'h5;
        // plain access, pin never asserted: armed attempt is abandoned
        slow = 1'($urandom);
        access($urandom, 1'b0, 1'b0, "plain access");
        repeat (8) @(negedge clk);
        chk(locked, 1'b0, "lock without pin");
        chk(post_en, 1'b1, "posting after plain access");
        chk(lk_oe, 1'b0, "card lock after plain access");
        for (int k = 0; k < 3; k++) begin
            slow = 1'b1;
            base = $urandom;
            // grant alone is no lock: lock pin idle at the start
            access(base, 1'b1, 1'b0, "lock start");
            chk(post_en, 1'b0, "posting during lock");
            for (int i = 0; i < 10 && locked !== 1'b1; i++) @(negedge clk);
            chk(locked, 1'b1, "lock not held");
            chk(lk_n, 1'b0, "card lock level");
            chk(lk_oe, 1'b1, "card lock drive");
            // other masters keep going outside the block
            repeat (4) begin
                slow = 1'($urandom);
                a = $urandom;
                if (hits(a, base)) a = a ^ 32'h10;
                access(a, 1'b1, 1'b0, "outside access");
            end
            // a writeback to another block is accepted like any outside access
            access(base ^ 32'h40, 1'b1, 1'b0, "writeback");
            // block edges and the neighbour block
            access({base[31:4], 4'h0}, 1'b1, 1'b1, "low edge");
            access({base[31:4], 4'hf}, 1'b1, 1'b1, "high edge");
            access(base ^ 32'h10, 1'b1, 1'b0, "next block");
            chk(post_en, 1'b0, "posting while held");
            // disabled: a lock drop on the pin is not seen at all
            ce = 1'b0;
            pin_n = 1'b1;
            repeat (8) @(negedge clk);
            chk(locked, 1'b1, "frozen lock kept");
            chk(post_en, 1'b0, "frozen posting");
            pin_n = 1'b0;
            ce = 1'b1;
            repeat (2) @(negedge clk);
            pin_n = 1'b1;
            for (int i = 0; i < 10 && locked !== 1'b0; i++) @(negedge clk);
            repeat (2) @(negedge clk);
            chk(post_en, 1'b1, "posting back");
            chk(lk_oe, 1'b0, "card lock released");
        end
        // reset in mid-lock drops everything back to idle
        slow = 1'b1;
        access(base, 1'b1, 1'b0, "relock start");
        for (int i = 0; i < 10 && locked !== 1'b1; i++) @(negedge clk);
        chk(locked, 1'b1, "relock held");
        srst = 1'b1;
        pin_n = 1'b1;
        repeat (2) @(negedge clk);
        srst = 1'b0;
        chk(locked, 1'b0, "lock after mid reset");
        chk(post_en, 1'b1, "posting after mid reset");
        chk(lk_oe, 1'b0, "card enable after mid reset");
        chk(lk_n, 1'b1, "card level after mid reset");
        repeat (6) @(negedge clk);
        chk(locked, 1'b0, "idle after mid reset");
        close_out;
    end
    // hang guard, well beyond the planned run
    initial begin
        #(40 * 3000);
        err_count++;
        close_out;
    end
endmodule
